// ### hdl/tcu_pkg.sv
// Constants shared by the compare channel and its base timer.
// Assumes a single clock domain on clk_sys at 50 MHz.
package tcu_pkg;

  // Widths of the channel control register, the compare value and timer, and one register byte.
  localparam int CTRL_W  = 8;
  localparam int COUNT_W = 16;
  localparam int BYTE_W  = 8;

  // Position of the mode field inside the channel control register.
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;

  // Mode field encodings.
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SW_EVT  = 4'hA;
  localparam logic [3:0] MODE_TRIGGER = 4'hB;

  // Reset values, the count maximum and the count step.
  localparam logic [CTRL_W-1:0]  CTRL_RST    = 8'h00;
  localparam logic [COUNT_W-1:0] COMPARE_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RST   = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

  // One-hot states of the pending timer reset.
  typedef enum logic [1:0] {
    RST_IDLE  = 2'b01,
    RST_ARMED = 2'b10
  } tcu_rst_state_t;

  // True for the modes in which the channel drives the compare pin.
  function automatic logic tcu_is_pin_mode(input logic [3:0] mode);
    tcu_is_pin_mode = (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR);
  endfunction

endpackage

// ### hdl/tcu_base_timer.sv
// Free-running 16-bit base timer with a sticky overflow flag.
// Assumes count_tick is a one-cycle pulse per rising edge of the timer clock.
`timescale 1ns/100ps
module tcu_base_timer
  import tcu_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // Counting control.
  input  wire logic               count_tick,
  input  wire logic               count_clear,
  input  wire logic               overflow_clr,
  // Timer state.
  output logic [COUNT_W-1:0]      count,
  output logic                    overflow_flag
);

  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               ovf_reg;
  logic               ovf_next;

  always_comb begin
    count_next = count_reg;
    ovf_next   = ovf_reg & ~overflow_clr;
    if (count_tick) begin
      if (count_clear) begin
        // A clear from the conversion trigger never raises the overflow flag.
        count_next = COUNT_RST;
      end else begin
        count_next = count_reg + COUNT_ONE;
        if (count_reg == COUNT_MAX) begin
          ovf_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_reg <= COUNT_RST;
      ovf_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign count         = count_reg;
  assign overflow_flag = ovf_reg;

endmodule // tcu_base_timer

// ### hdl/tcu_compare.sv
// Compare channel of the timer compare unit, with its base timer.
// Assumes all inputs are synchronous to clk_sys and write strobes are one-cycle pulses.
//
// Notes on behaviour
// - Compare value and base timer count are compared every cycle; equality is a match.
// - A match acts per mode field: toggle, set, clear pin, trigger or software event.
// - Every compare mode sets the event flag in the same cycle as the action.
// - Writing zero to the control register forces the compare latch low.
// - Mode 1010 only raises the software event; the pin is left alone.
// - Mode 1011 resets the base timer and triggers a conversion; pin undriven.
// - Trigger is immediate; timer clears at the next base timer clock edge.
// - A timer clear from the trigger does not set the overflow flag.
// - If the match is gone before that edge, the pending timer clear is cancelled.
// - Compare needs the system clock and is halted during sleep.
`timescale 1ns/100ps
module tcu_compare
  import tcu_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // Register writes.
  input  wire logic [BYTE_W-1:0]  wr_data,
  input  wire logic               ctrl_wr,
  input  wire logic               compare_value_low_wr,
  input  wire logic               compare_value_high_wr,
  // Flag clears.
  input  wire logic               event_flag_clr,
  input  wire logic               overflow_flag_clr,
  // Surroundings.
  input  wire logic               base_timer_tick,
  input  wire logic               pin_direction_bit,
  input  wire logic               sleep_active,
  // Register contents.
  output logic [CTRL_W-1:0]       channel_control_register,
  output logic [BYTE_W-1:0]       compare_value_low,
  output logic [BYTE_W-1:0]       compare_value_high,
  output logic [BYTE_W-1:0]       base_timer_low,
  output logic [BYTE_W-1:0]       base_timer_high,
  // Flags.
  output logic                    channel_event_flag,
  output logic                    base_timer_overflow_flag,
  // Pin and trigger.
  output logic                    compare_pin_out,
  output logic                    compare_pin_oe,
  output logic                    conversion_trigger
);

  logic [CTRL_W-1:0]  ctrl_reg;
  logic [CTRL_W-1:0]  ctrl_next;
  logic [COUNT_W-1:0] cmp_reg;
  logic [COUNT_W-1:0] cmp_next;
  logic               latch_reg;
  logic               latch_next;
  logic               flag_reg;
  logic               flag_next;
  logic               trig_reg;
  logic               trig_next;
  logic               match_prev_reg;
  logic               match_prev_next;
  tcu_rst_state_t     rst_state_reg;
  tcu_rst_state_t     rst_state_next;

  logic [COUNT_W-1:0] count;
  logic [3:0]         mode;
  logic               match_now;
  logic               match_rise;
  logic               timer_clear;

  assign mode      = ctrl_reg[MODE_MSB:MODE_LSB];
  // Sleep stops the system clock on the real device; here it halts matching.
  assign match_now  = ~sleep_active & (cmp_reg == count);
  // Act once per arrival at the compare value, not on every cycle it is held.
  assign match_rise = match_now & ~match_prev_reg;

  // Register group: control, compare value, latch, flag and trigger.
  always_comb begin
    ctrl_next       = ctrl_reg;
    cmp_next        = cmp_reg;
    latch_next      = latch_reg;
    flag_next       = flag_reg & ~event_flag_clr;
    trig_next       = 1'b0;
    match_prev_next = match_now;
    if (compare_value_low_wr) begin
      cmp_next[BYTE_W-1:0] = wr_data;
    end
    if (compare_value_high_wr) begin
      cmp_next[COUNT_W-1:BYTE_W] = wr_data;
    end
    if (match_rise && mode != MODE_OFF) begin
      // The flag set wins over a clear in the same cycle.
      flag_next = 1'b1;
      case (mode)
        MODE_TOGGLE:  latch_next = ~latch_reg;
        MODE_SET:     latch_next = 1'b1;
        MODE_CLEAR:   latch_next = 1'b0;
        MODE_SW_EVT:  latch_next = latch_reg;
        MODE_TRIGGER: trig_next  = 1'b1;
        default:      latch_next = latch_reg;
      endcase
    end
    if (ctrl_wr) begin
      ctrl_next = wr_data;
      if (wr_data == CTRL_RST) begin
        latch_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg       <= CTRL_RST;
      cmp_reg        <= COMPARE_RST;
      latch_reg      <= 1'b0;
      flag_reg       <= 1'b0;
      trig_reg       <= 1'b0;
      match_prev_reg <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      cmp_reg        <= cmp_next;
      latch_reg      <= latch_next;
      flag_reg       <= flag_next;
      trig_reg       <= trig_next;
      match_prev_reg <= match_prev_next;
    end
  end

  // Pending timer reset group.
  always_comb begin
    rst_state_next = rst_state_reg;
    timer_clear    = 1'b0;
    case (rst_state_reg)
      RST_IDLE: begin
        if (match_rise && mode == MODE_TRIGGER) begin
          rst_state_next = RST_ARMED;
        end
      end
      RST_ARMED: begin
        if (base_timer_tick) begin
          // The clear happens only if the compare value still matches.
          // A fresh trigger on this very tick re-arms instead, so its clear waits for the next tick.
          timer_clear    = match_now & ~(match_rise & (mode == MODE_TRIGGER));
          rst_state_next = (match_rise && mode == MODE_TRIGGER) ? RST_ARMED : RST_IDLE;
        end
      end
      default: rst_state_next = RST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_state_reg <= RST_IDLE;
    end else begin
      rst_state_reg <= rst_state_next;
    end
  end

  // The base timer advances on the tick supplied by its clock source.
  tcu_base_timer u_base_timer (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .count_tick    (base_timer_tick),
    .count_clear   (timer_clear),
    .overflow_clr  (overflow_flag_clr),
    .count         (count),
    .overflow_flag (base_timer_overflow_flag)
  );

  assign channel_control_register = ctrl_reg;
  assign compare_value_low        = cmp_reg[BYTE_W-1:0];
  assign compare_value_high       = cmp_reg[COUNT_W-1:BYTE_W];
  assign base_timer_low           = count[BYTE_W-1:0];
  assign base_timer_high          = count[COUNT_W-1:BYTE_W];
  assign channel_event_flag       = flag_reg;
  assign conversion_trigger       = trig_reg;
  assign compare_pin_out          = latch_reg;
  // The pin is driven only in pin modes and only once software made it an output.
  assign compare_pin_oe           = tcu_is_pin_mode(mode) & ~pin_direction_bit;

  // Checks.
  sequence trig_match_s;
    match_rise && mode == MODE_TRIGGER;
  endsequence

  sequence armed_tick_s;
    rst_state_reg == RST_ARMED && base_timer_tick;
  endsequence

  event_flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    match_rise && mode != MODE_OFF |=> channel_event_flag)
    else $error("Event flag not set after a match.");

  match_on_equal_a: assert property (@(posedge clk_sys) disable iff (srst)
    !sleep_active && cmp_reg == count && !match_prev_reg && mode == MODE_SW_EVT |=> channel_event_flag)
    else $error("Equal count did not raise a match.");

  toggle_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
    match_rise && mode == MODE_TOGGLE && !ctrl_wr |=> compare_pin_out != $past(compare_pin_out))
    else $error("Toggle mode did not invert the latch.");

  zero_ctrl_a: assert property (@(posedge clk_sys) disable iff (srst)
    ctrl_wr && wr_data == CTRL_RST |=> !compare_pin_out && channel_control_register == CTRL_RST)
    else $error("Zero control write left the latch high.");

  sw_event_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
    mode == MODE_SW_EVT |-> !compare_pin_oe ##1 compare_pin_out == $past(compare_pin_out) || $past(ctrl_wr))
    else $error("Software event mode touched the pin.");

  trig_issue_a: assert property (@(posedge clk_sys) disable iff (srst)
    trig_match_s |-> !compare_pin_oe ##1 conversion_trigger ##1 !conversion_trigger)
    else $error("Trigger mode did not pulse the conversion trigger once.");

  clear_after_tick_a: assert property (@(posedge clk_sys) disable iff (srst)
    armed_tick_s ##0 (match_now && !match_rise) |=> count == COUNT_RST)
    else $error("Timer not cleared at the next base timer edge.");

  no_early_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    trig_match_s |-> !timer_clear)
    else $error("Timer cleared in the trigger cycle.");

  no_ovf_on_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    timer_clear && !base_timer_overflow_flag |=> !base_timer_overflow_flag)
    else $error("Trigger clear set the overflow flag.");

  cancel_reset_a: assert property (@(posedge clk_sys) disable iff (srst)
    armed_tick_s and !match_now |-> !timer_clear ##1 rst_state_reg == RST_IDLE)
    else $error("Pending clear not cancelled after match was lost.");

  sleep_halt_a: assert property (@(posedge clk_sys) disable iff (srst)
    sleep_active |-> !match_rise ##1 !conversion_trigger)
    else $error("Match acted during sleep.");

endmodule // tcu_compare

// ### test/tcu_tick_src.sv
// Far-side model: base timer clock source and converter trigger input.
// Assumes the bench drives run off the rising edge; ticks are synchronous.
`timescale 1ns/100ps
module tcu_tick_src (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Control and trigger.
  input  wire logic       run,
  input  wire logic       conversion_trigger,
  // Tick and trigger tally.
  output logic            base_timer_tick,
  output logic [7:0]      trig_count
);
  logic [1:0] div_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_reg    <= 2'h0;
      trig_count <= 8'h00;
    end else begin
      div_reg    <= run ? div_reg + 2'h1 : 2'h0;
      trig_count <= trig_count + {7'h00, conversion_trigger};
    end
  end
  // The timer ticks synchronously at one quarter of the system clock.
  assign base_timer_tick = run && (div_reg == 2'h3);
endmodule // tcu_tick_src

// ### test/tb_top.sv
// Self-checking bench for the compare channel, with a cycle model of it.
// Assumes the design and tcu_tick_src are compiled first.
`timescale 1ns/100ps
module tb_top;
  import tcu_pkg::*;
  logic       clk_sys = 1'b0, srst = 1'b1, ctrl_wr = 1'b0, lo_wr = 1'b0, hi_wr = 1'b0;
  logic       ev_clr = 1'b0, ov_clr = 1'b0, dir = 1'b1, slp = 1'b0, run = 1'b0, tick;
  logic [7:0] wr_data = 8'h00, ctrl_q, cl_q, ch_q, tl_q, th_q, n_trig, m_ctrl, m_cl, m_ch, m_ntrig;
  logic       ev_q, ov_q, pin_q, oe_q, trig_q, m_ev, m_ov, m_pin, m_trig, m_pend, m_prev;
  logic [15:0] m_cnt;
  logic [3:0] modes [7] = '{MODE_OFF, MODE_TOGGLE, MODE_SET, MODE_CLEAR, 4'h5, MODE_SW_EVT, MODE_TRIGGER};
  int         n_errors = 0, n_tests = 0, cyc = 0;

  always #10 clk_sys = ~clk_sys;

  tcu_compare i_dut (.clk_sys(clk_sys), .srst(srst), .wr_data(wr_data), .ctrl_wr(ctrl_wr),
    .compare_value_low_wr(lo_wr), .compare_value_high_wr(hi_wr), .event_flag_clr(ev_clr),
    .overflow_flag_clr(ov_clr), .base_timer_tick(tick), .pin_direction_bit(dir), .sleep_active(slp),
    .channel_control_register(ctrl_q), .compare_value_low(cl_q), .compare_value_high(ch_q),
    .base_timer_low(tl_q), .base_timer_high(th_q), .channel_event_flag(ev_q),
    .base_timer_overflow_flag(ov_q), .compare_pin_out(pin_q), .compare_pin_oe(oe_q),
    .conversion_trigger(trig_q));
  tcu_tick_src i_far (.clk_sys(clk_sys), .srst(srst), .run(run), .conversion_trigger(trig_q),
    .base_timer_tick(tick), .trig_count(n_trig));

  function automatic logic drives_pin(input logic [3:0] m);
    return m == 4'h2 || m == 4'h8 || m == 4'h9;
  endfunction

  // Reference model, one step per rising edge.
  always @(posedge clk_sys) begin
    logic eq, mnow, hit, act, clr;
    logic [3:0] md;
    md   = m_ctrl[3:0];
    eq   = ({m_ch, m_cl} == m_cnt);
    mnow = !slp && eq;
    hit  = mnow && !m_prev;
    act  = hit && md != MODE_OFF;
    clr  = tick && m_pend && eq && !(hit && md == MODE_TRIGGER);
    if (srst) begin
      {m_ctrl, m_cl, m_ch, m_ntrig} <= 32'h0;
      {m_cnt, m_ev, m_ov, m_pin, m_trig, m_pend, m_prev} <= 22'h0;
    end else begin
      m_prev  <= mnow;
      m_trig  <= hit && md == MODE_TRIGGER;
      m_ntrig <= m_ntrig + {7'h00, m_trig};
      m_ev    <= act || (m_ev && !ev_clr);
      m_pend  <= (hit && md == MODE_TRIGGER) ? 1'b1 : (tick ? 1'b0 : m_pend);
      if (tick) m_cnt <= clr ? 16'h0000 : m_cnt + 16'h0001;
      m_ov    <= (tick && !clr && m_cnt == 16'hFFFF) || (m_ov && !ov_clr);
      if (ctrl_wr && wr_data == 8'h00) m_pin <= 1'b0;
      else if (hit && md == MODE_TOGGLE) m_pin <= !m_pin;
      else if (hit && md == MODE_SET) m_pin <= 1'b1;
      else if (hit && md == MODE_CLEAR) m_pin <= 1'b0;
      if (ctrl_wr) m_ctrl <= wr_data;
      if (lo_wr) m_cl <= wr_data;
      if (hi_wr) m_ch <= wr_data;
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step();
    @(negedge clk_sys);
    if (!srst) begin
      chk("control", {8'h00, m_ctrl}, {8'h00, ctrl_q});
      chk("compare", {m_ch, m_cl}, {ch_q, cl_q});
      chk("count", m_cnt, {th_q, tl_q});
      chk("event", {15'h0, m_ev}, {15'h0, ev_q});
      chk("overflow", {15'h0, m_ov}, {15'h0, ov_q});
      chk("pin", {15'h0, m_pin}, {15'h0, pin_q});
      chk("pin enable", {15'h0, drives_pin(m_ctrl[3:0]) && !dir}, {15'h0, oe_q});
      chk("trigger", {15'h0, m_trig}, {15'h0, trig_q});
    end
  endtask

  task automatic wr(input int k, input logic [7:0] d);
    step();
    wr_data = d;
    ctrl_wr = (k == 0);
    lo_wr   = (k == 1);
    hi_wr   = (k == 2);
    step();
    {ctrl_wr, lo_wr, hi_wr} = 3'b000;
  endtask

  task automatic set_cmp(input logic [15:0] v);
    wr(1, v[7:0]);
    wr(2, v[15:8]);
  endtask

  task automatic await_event();
    step();
    ev_clr = 1'b1;
    step();
    ev_clr = 1'b0;
    for (int i = 0; i < 80 && m_ev !== 1'b1; i++) step();
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'h1b93));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    dir  = 1'b0;
    run  = 1'b1;
    foreach (modes[i]) begin
      wr(0, {4'h0, modes[i]});
      set_cmp(m_cnt + 16'h0010);
      await_event();
    end
    wr(0, {4'h0, MODE_SET});
    set_cmp(m_cnt + 16'h0010);
    await_event();
    wr(0, 8'h00);
    // Trigger with the timer halted, kept and then cancelled.
    for (int c = 0; c < 2; c++) begin
      run = 1'b0;
      wr(0, {4'h0, MODE_TRIGGER});
      set_cmp(m_cnt);
      if (c == 1) wr(1, ~m_cl);
      run = 1'b1;
      repeat (12) step();
    end
    slp = 1'b1;
    wr(0, {4'h0, MODE_TOGGLE});
    set_cmp(m_cnt + 16'h0008);
    repeat (60) step();
    slp = 1'b0;
    repeat (4000) begin
      int r;
      step();
      r = $urandom % 16;
      wr_data = (r == 0) ? {4'h0, modes[$urandom % 7]} :
                (r == 2) ? m_cnt[15:8] : m_cnt[7:0] + 8'($urandom % 8);
      ctrl_wr = (r == 0);
      lo_wr   = (r == 1);
      hi_wr   = (r == 2);
      ev_clr  = (r == 3);
      ov_clr  = (r == 4);
      if (r == 5) dir = !dir;
      if (r == 6) slp = ($urandom % 4 == 0);
    end
    step();
    chk("trigger tally", {8'h00, m_ntrig}, {8'h00, n_trig});
    wrap_up();
  end
endmodule // tb_top
